// File: hdl/csr_map.svh
// Register offsets, field positions and reset values of the channel sequencer registers.
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CSR_ADDR_GPIN   8'h0D
`define CSR_ADDR_SCFG   8'h10
`define CSR_ADDR_MPICK  8'h11
`define CSR_ADDR_AMASK  8'h12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CSR_SCFG_GO_BIT    4
`define CSR_SCFG_MODE_MSB  1
`define CSR_SCFG_MODE_LSB  0
`define CSR_MPICK_ID_MSB   3
`define CSR_MPICK_ID_LSB   0
`define CSR_MPICK_RSV_BIT  3

// ----------------------------------------------------------------------------
// Reset values and scan step
// ----------------------------------------------------------------------------
`define CSR_RST_BYTE   8'h00
`define CSR_RST_MODE   2'h0
`define CSR_RST_ID     4'h0
`define CSR_RST_CHAN   3'h0
`define CSR_CHAN_STEP  3'h1

`endif

// File: hdl/csr_pkg.sv
// Types shared by the channel sequencer register files.
package csr_pkg;

    // Scan mode codes as held in the scan configuration register.
    typedef enum logic [1:0] {
        CSR_MODE_MANUAL = 2'h0,
        CSR_MODE_AUTO   = 2'h1,
        CSR_MODE_OTF    = 2'h2,
        CSR_MODE_RSVD   = 2'h3
    } csr_mode_e;

    // Conversion launcher states, one-hot.
    typedef enum logic [1:0] {
        CSR_ST_IDLE = 2'b01,
        CSR_ST_BUSY = 2'b10
    } csr_state_e;

    // Whole state of the register block.
    typedef struct packed {
        csr_state_e st;
        csr_mode_e  mode;
        logic       go;
        logic [3:0] man_id;
        logic [7:0] mask;
        logic [2:0] seq_ch;
        logic [2:0] conv_ch;
        logic       conv_req;
        logic       run;
        logic [7:0] rdata;
        logic       ack;
    } csr_regs_s;

    // State of the pin level synchroniser.
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] level;
    } csr_sync_s;

endpackage

// File: hdl/csr_gpio_sync.sv
// Two-stage synchroniser for the eight channel pin levels.
`timescale 1ns/1ps
module csr_gpio_sync (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [7:0] pins,
    output logic      [7:0] level
);
    `include "csr_map.svh"

    csr_pkg::csr_sync_s q;
    csr_pkg::csr_sync_s d;

    // The first stage feeds only the second, so metastability never spreads.
    always_comb begin
        d       = q;
        d.meta  = pins;
        d.level = q.meta;
    end

    // Both stages clear to zero so the readback starts at zero.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= {`CSR_RST_BYTE, `CSR_RST_BYTE};
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
endmodule

// File: hdl/csr_scan_pick.sv
// Finds the first enabled channel at or after a start channel, wrapping upward.
`timescale 1ns/1ps
module csr_scan_pick (
    input  wire logic [7:0] mask,
    input  wire logic [2:0] from,
    output logic            found,
    output logic      [2:0] chan
);

    logic [3:0] hit;

    // Returns {found, channel}; the loop runs down from offset seven, so the nearest channel upward, wrapping past seven, wins.
    function automatic logic [3:0] csr_pick(input logic [7:0] m, input logic [2:0] s);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            idx = s + 3'(i);
            if (m[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    // The search result is held in a net first, since a call cannot be sliced directly.
    assign hit   = csr_pick(mask, from);
    assign found = hit[3];
    assign chan  = hit[2:0];
endmodule

// File: hdl/csr_top.sv
// Channel sequencer register bank with pin readback and conversion launcher.
`timescale 1ns/1ps

// Behaviour
// - Each input level bit returns the present synchronised level of its channel pin.
// - Input level register is read only and resets to zero.
// - Scan configuration bits 7:5 and 3:2 always read zero.
// - Scan mode field bits 1:0: manual, automatic, on-the-fly, reserved.
// - Sequence go bit starts or stops sequencing, only in automatic mode.
// - Automatic sequencing visits only masked channels in ascending order.
// - Each mask bit includes its channel when one, excludes it when zero.
// - Manual mode converts the channel given by the manual channel id.
// - Manual channel register bits 7:4 read zero; id sits in 3:0.
// - Pin function bit one makes a channel a GPIO, unfit for conversion.
// - Trigger mode zero lets the host start conversions, one starts internally.
module csr_top (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata_q,
    output logic            reg_ack_q,
    input  wire logic [7:0] gpio_pins,
    input  wire logic [7:0] pin_function_sel,
    input  wire logic       conversion_trigger_mode,
    input  wire logic       host_conv_start,
    input  wire logic       conv_done,
    output logic            conv_req_q,
    output logic      [2:0] conv_channel_q,
    output logic      [1:0] scan_mode_q,
    output logic            seq_running_q
);
    `include "csr_map.svh"

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    csr_pkg::csr_regs_s q;
    csr_pkg::csr_regs_s d;
    logic [7:0]         input_pin_levels;
    logic [7:0]         eff_mask;
    logic               pick_found;
    logic [2:0]         pick_chan;
    logic               is_manual;
    logic               run_now;
    logic               chan_ok;
    logic [2:0]         launch_ch;
    logic               trig;

    // ------------------------------------------------------------------------
    // Pin readback and channel search
    // ------------------------------------------------------------------------

    // Pins are asynchronous to sys_clk, so they pass two flops first.
    csr_gpio_sync u_sync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pins    (gpio_pins),
        .level   (input_pin_levels)
    );

    // GPIO channels are dropped from the scan even when the mask enables them.
    assign eff_mask = q.mask & ~pin_function_sel;

    csr_scan_pick u_pick (
        .mask  (eff_mask),
        .from  (q.seq_ch),
        .found (pick_found),
        .chan  (pick_chan)
    );

    // ------------------------------------------------------------------------
    // Launch conditions
    // ------------------------------------------------------------------------

    // Channel choice per mode; on-the-fly and reserved modes launch nothing here.
    always_comb begin
        is_manual = (q.mode == csr_pkg::CSR_MODE_MANUAL);
        run_now   = (q.mode == csr_pkg::CSR_MODE_AUTO) && q.go;
        launch_ch = is_manual ? q.man_id[2:0] : pick_chan;
        chan_ok   = 1'b0;
        if (is_manual) begin
            // A reserved id is refused rather than aliased onto a channel.
            chan_ok = !q.man_id[`CSR_MPICK_RSV_BIT] && !pin_function_sel[launch_ch];
        end else if (run_now) begin
            chan_ok = pick_found;
        end
        trig = conversion_trigger_mode ? 1'b1 : host_conv_start;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Register writes, reads and the launcher share one next-state copy.
    always_comb begin
        d          = q;
        d.conv_req = 1'b0;
        d.ack      = reg_wr || reg_rd;

        // Only writable fields are stored; reserved positions are never kept.
        if (reg_wr) begin
            unique case (reg_addr)
                `CSR_ADDR_SCFG: begin
                    d.mode = csr_pkg::csr_mode_e'(
                        reg_wdata[`CSR_SCFG_MODE_MSB:`CSR_SCFG_MODE_LSB]);
                    d.go   = reg_wdata[`CSR_SCFG_GO_BIT];
                end
                `CSR_ADDR_MPICK: begin
                    d.man_id = reg_wdata[`CSR_MPICK_ID_MSB:`CSR_MPICK_ID_LSB];
                end
                `CSR_ADDR_AMASK: begin
                    d.mask = reg_wdata;
                end
                default: begin
                    // Input level register and unmapped offsets ignore writes.
                end
            endcase
        end

        // Read data holds until the next read; unmapped offsets return zero.
        if (reg_rd) begin
            unique case (reg_addr)
                `CSR_ADDR_GPIN: begin
                    d.rdata = input_pin_levels;
                end
                `CSR_ADDR_SCFG: begin
                    d.rdata = {3'h0, q.go, 2'h0, q.mode};
                end
                `CSR_ADDR_MPICK: begin
                    d.rdata = {4'h0, q.man_id};
                end
                `CSR_ADDR_AMASK: begin
                    d.rdata = q.mask;
                end
                default: begin
                    d.rdata = `CSR_RST_BYTE;
                end
            endcase
        end

        // Stopping or leaving automatic mode restarts the scan at channel zero.
        if (!run_now) begin
            d.seq_ch = `CSR_RST_CHAN;
        end

        // One conversion in flight at a time; the engine ends it with conv_done.
        unique case (q.st)
            csr_pkg::CSR_ST_IDLE: begin
                if (chan_ok && trig) begin
                    d.conv_req = 1'b1;
                    d.conv_ch  = launch_ch;
                    d.st       = csr_pkg::CSR_ST_BUSY;
                end
            end
            csr_pkg::CSR_ST_BUSY: begin
                if (conv_done) begin
                    d.st = csr_pkg::CSR_ST_IDLE;
                    if (run_now) begin
                        d.seq_ch = q.conv_ch + `CSR_CHAN_STEP;
                    end
                end
            end
            default: begin
                d.st = csr_pkg::CSR_ST_IDLE;
            end
        endcase

        d.run = (d.mode == csr_pkg::CSR_MODE_AUTO) && d.go;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Every field but the state, which loads idle, clears to zero, so the block wakes in manual mode, stopped.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q.st       <= csr_pkg::CSR_ST_IDLE;
            q.mode     <= csr_pkg::CSR_MODE_MANUAL;
            q.go       <= 1'b0;
            q.man_id   <= `CSR_RST_ID;
            q.mask     <= `CSR_RST_BYTE;
            q.seq_ch   <= `CSR_RST_CHAN;
            q.conv_ch  <= `CSR_RST_CHAN;
            q.conv_req <= 1'b0;
            q.run      <= 1'b0;
            q.rdata    <= `CSR_RST_BYTE;
            q.ack      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // All outputs are fields of the state register.
    assign reg_rdata_q    = q.rdata;
    assign reg_ack_q      = q.ack;
    assign conv_req_q     = q.conv_req;
    assign conv_channel_q = q.conv_ch;
    assign scan_mode_q    = q.mode;
    assign seq_running_q  = q.run;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------

    a_gpin_readback: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_rd && (reg_addr == `CSR_ADDR_GPIN) |=> reg_rdata_q == $past(input_pin_levels))
        else $error("Input level readback differs from the pin levels.");

    a_gpin_reset_zero: assert property (
        @(posedge sys_clk)
        srst ##1 (reg_rd && (reg_addr == `CSR_ADDR_GPIN)) |=> reg_rdata_q == 8'h00)
        else $error("Input level register is not zero right after reset.");

    a_scfg_reserved: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_rd && (reg_addr == `CSR_ADDR_SCFG) |=>
            (reg_rdata_q[7:5] == 3'h0) && (reg_rdata_q[3:2] == 2'h0))
        else $error("Reserved scan configuration bits read nonzero.");

    a_mode_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_wr && (reg_addr == `CSR_ADDR_SCFG) |=>
            (scan_mode_q == $past(reg_wdata[1:0])) && (q.go == $past(reg_wdata[4])))
        else $error("Scan mode or go bit not stored from the write.");

    a_auto_needs_go: assert property (
        @(posedge sys_clk) disable iff (srst)
        conv_req_q && !$past(is_manual) |-> $past(q.go) && $past(q.mode == csr_pkg::CSR_MODE_AUTO))
        else $error("Automatic launch without the go bit in automatic mode.");

    a_auto_in_mask: assert property (
        @(posedge sys_clk) disable iff (srst)
        d.conv_req && run_now |-> eff_mask[d.conv_ch])
        else $error("Automatic launch on a channel outside the scan mask.");

    a_auto_ascend: assert property (
        @(posedge sys_clk) disable iff (srst)
        q.st == csr_pkg::CSR_ST_BUSY && conv_done && run_now |=> q.seq_ch == $past(q.conv_ch) + 3'h1)
        else $error("Scan did not move to the channel above the last one.");

    a_manual_chan: assert property (
        @(posedge sys_clk) disable iff (srst)
        conv_req_q && $past(is_manual) |-> conv_channel_q == $past(q.man_id[2:0]))
        else $error("Manual launch used a channel other than the manual id.");

    a_mpick_reserved: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_rd && (reg_addr == `CSR_ADDR_MPICK) |=> reg_rdata_q[7:4] == 4'h0)
        else $error("Reserved manual channel bits read nonzero.");

    a_gpio_not_conv: assert property (
        @(posedge sys_clk) disable iff (srst)
        d.conv_req |-> !pin_function_sel[d.conv_ch])
        else $error("Conversion launched on a channel set up as GPIO.");

    a_host_trigger: assert property (
        @(posedge sys_clk) disable iff (srst)
        conv_req_q && !$past(conversion_trigger_mode) |-> $past(host_conv_start))
        else $error("Host trigger mode launched without a host start.");

    a_empty_mask: assert property (
        @(posedge sys_clk) disable iff (srst)
        (eff_mask == 8'h00) && !is_manual |=> !conv_req_q)
        else $error("Automatic launch with an empty scan mask.");

    a_amask_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_wr && (reg_addr == `CSR_ADDR_AMASK) |=> q.mask == $past(reg_wdata))
        else $error("Scan mask not stored from the write.");

    a_gpin_ro: assert property (
        @(posedge sys_clk) disable iff (srst)
        reg_wr && (reg_addr == `CSR_ADDR_GPIN) |=>
            $stable(q.mask) && $stable(q.man_id) && $stable(q.mode) && $stable(q.go))
        else $error("A write to the input level register changed a stored field.");

    a_stop_rewinds: assert property (
        @(posedge sys_clk) disable iff (srst)
        !run_now |=> q.seq_ch == `CSR_RST_CHAN)
        else $error("Scan pointer not rewound while sequencing is stopped.");

    a_idle_modes: assert property (
        @(posedge sys_clk) disable iff (srst)
        !is_manual && !run_now |=> !conv_req_q)
        else $error("Launch outside manual mode and a running automatic scan.");

    a_manual_rsvd_id: assert property (
        @(posedge sys_clk) disable iff (srst)
        is_manual && q.man_id[`CSR_MPICK_RSV_BIT] |=> !conv_req_q)
        else $error("Manual launch with a reserved channel id.");

    a_req_single: assert property (
        @(posedge sys_clk) disable iff (srst)
        conv_req_q |=> !conv_req_q)
        else $error("Launch pulse lasted longer than one cycle.");

endmodule

// File: testbench/csr_conv_model.sv
// Conversion engine stand-in that ends each launched conversion after a chosen delay.
`timescale 1ns/1ps
module csr_conv_model (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic conv_req_q,
    input  wire logic slow,
    output logic      conv_done
);
    logic [3:0] left_q;
    // A launch loads the delay; a done pulse never comes without a launch before it.
    always_ff @(posedge sys_clk) begin
        conv_done <= 1'b0;
        if (srst) begin
            left_q <= 4'h0;
        end else if (conv_req_q) begin
            left_q <= slow ? 4'h9 : 4'h1;
        end else if (left_q != 4'h0) begin
            left_q    <= left_q - 4'h1;
            conv_done <= (left_q == 4'h1);
        end
    end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the channel sequencer register bank.
`timescale 1ns/1ps
module tb;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  gpio_pins = 8'h00;
    logic [7:0]  pfs = 8'h00;
    logic        trig = 1'b0;
    logic        hstart = 1'b0;
    logic        slow = 1'b0;
    logic        conv_done;
    logic [7:0]  rdata;
    logic        ack;
    logic        creq;
    logic [2:0]  cch;
    logic [1:0]  smode;
    logic        srun;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'hEF194FCB;
    logic [2:0]  got[$];
    logic [7:0]  rd, v, em;
    logic [2:0]  p, e;

    always #5 sys_clk = ~sys_clk;

    csr_top csr_top_i (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .reg_ack_q(ack),
        .gpio_pins(gpio_pins), .pin_function_sel(pfs), .conversion_trigger_mode(trig),
        .host_conv_start(hstart), .conv_done(conv_done), .conv_req_q(creq),
        .conv_channel_q(cch), .scan_mode_q(smode), .seq_running_q(srun));
    csr_conv_model csr_conv_model_i (.sys_clk(sys_clk), .srst(srst), .conv_req_q(creq),
        .slow(slow), .conv_done(conv_done));

    // Record every launch; the cycle ceiling cuts a hung run short.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (creq === 1'b1) begin
            got.push_back(cch);
        end
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // Galois-free shift register; the fixed seed keeps runs repeatable.
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction

    // First enabled channel at or after a start channel, wrapping upward.
    function automatic logic [2:0] next_ch(input logic [7:0] m, input logic [2:0] from);
        for (int i = 0; i < 8; i++) begin
            if (m[3'(from + i)]) begin
                return 3'(from + i);
            end
        end
        return 3'h0;
    endfunction

    task automatic check(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, x);
        end
    endtask

    // One register cycle; the answer is due exactly one cycle after the strobe.
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= wd;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        check({7'h00, ack}, 8'h01);
        rd = rdata;
    endtask

    task automatic wait_clr(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
        got.delete();
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset images, reserved bits and an unmapped offset.
        reg_acc(0, 8'h0D, 8'h00); check(rd, 8'h00);
        reg_acc(0, 8'h10, 8'h00); check(rd, 8'h00);
        reg_acc(0, 8'h11, 8'h00); check(rd, 8'h00);
        reg_acc(0, 8'h12, 8'h00); check(rd, 8'h00);
        reg_acc(1, 8'h10, 8'hFF); reg_acc(0, 8'h10, 8'h00); check(rd, 8'h13);
        reg_acc(1, 8'h10, 8'h00);
        reg_acc(1, 8'h11, 8'hFF); reg_acc(0, 8'h11, 8'h00); check(rd, 8'h0F);
        reg_acc(0, 8'h33, 8'h00); check(rd, 8'h00);
        // Random pin levels and mask values read back after synchronising.
        for (int k = 0; k < 6; k++) begin
            v = rnd();
            gpio_pins <= v;
            reg_acc(1, 8'h0D, ~v);
            reg_acc(0, 8'h0D, 8'h00); check(rd, v);
            reg_acc(1, 8'h12, v); reg_acc(0, 8'h12, 8'h00); check(rd, v);
        end
        // Manual picks, including a reserved id and a start while busy.
        slow <= 1'b1;
        for (int id = 0; id < 9; id++) begin
            v = rnd();
            pfs <= v;
            reg_acc(1, 8'h11, 8'(id));
            wait_clr(1);
            hstart <= 1'b1;
            @(posedge sys_clk);
            @(posedge sys_clk);
            hstart <= 1'b0;
            repeat (14) @(posedge sys_clk);
            #1;
            e = 3'(id);
            check(8'(got.size()), (id < 8 && !v[e]) ? 8'h01 : 8'h00);
            if (got.size() == 1) begin
                check({5'h00, got[0]}, {5'h00, e});
            end
        end
        // Host trigger mode never starts an automatic scan by itself; on-the-fly mode with internal trigger launches nothing.
        pfs <= 8'h00;
        reg_acc(1, 8'h12, 8'hFF);
        reg_acc(1, 8'h10, 8'h11);
        wait_clr(1);
        repeat (20) @(posedge sys_clk);
        #1;
        check(8'(got.size()), 8'h00);
        reg_acc(1, 8'h10, 8'h12);
        trig <= 1'b1;
        wait_clr(2);
        repeat (20) @(posedge sys_clk);
        #1;
        check(8'(got.size()), 8'h00);
        // Random automatic scans, prompt and slow, then a stop.
        for (int t = 0; t < 6; t++) begin
            v = (t == 0) ? 8'h00 : rnd();
            slow <= t[0];
            pfs <= v;
            em = (t == 0) ? 8'h00 : rnd(); // First pass is the empty-mask corner.
            reg_acc(1, 8'h12, em);
            em = em & ~v;
            reg_acc(1, 8'h10, 8'h11);
            wait_clr(0);
            check({5'h00, smode, srun}, 8'h03);
            repeat (60) @(posedge sys_clk);
            #1;
            if (em == 8'h00) begin
                check(8'(got.size()), 8'h00);
            end else if (got.size() < 4) begin
                check(8'(got.size()), 8'h04);
            end else begin
                p = 3'h0;
                for (int k = 0; k < 4; k++) begin
                    e = next_ch(em, p);
                    check({5'h00, got[k]}, {5'h00, e});
                    p = e + 3'h1;
                end
            end
            reg_acc(1, 8'h10, 8'h01);
            wait_clr(2);
            repeat (20) @(posedge sys_clk);
            #1;
            check({7'h00, srun} | 8'(got.size()), 8'h00);
        end
        // Mid-run reset with a read at the first edge after release: the pin
        // register reports zero there and shows the pins two edges later.
        gpio_pins <= 8'hA5;
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst     <= 1'b0;
        reg_rd   <= 1'b1;
        reg_addr <= 8'h0D;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check({7'h00, ack}, 8'h01);
        check(rdata, 8'h00);
        reg_acc(0, 8'h12, 8'h00); check(rd, 8'h00);
        reg_acc(0, 8'h10, 8'h00); check(rd, 8'h00);
        reg_acc(0, 8'h0D, 8'h00); check(rd, 8'hA5);
        finish_test();
    end
endmodule
